//--- rtl/mcw_consts.vh
// Purpose: shared constants for the master control word decoder
// Assumes: 40 MHz system clock, 32 channels of 8 bits per frame
// Notes:   definitions only
`ifndef MCW_CONSTS_VH
`define MCW_CONSTS_VH

// ==========================================================
// control stream channel positions
`define WORD_ONE_CHAN    5'h0F
`define WORD_TWO_CHAN    5'h1F
`define SIG_SLOT         5'h10
`define LAST_BIT         3'h7

// ==========================================================
// word one fields
`define W1_LOOP_BIT      6
`define W1_NODB_MSB      3
`define W1_RESET         8'hB0

// ==========================================================
// word two fields
`define W2_CCS_BIT       5
`define W2_FPEN_BIT      4
`define W2_AIS_BIT       3
`define W2_TS16AIS_BIT   2
`define W2_EXT_BIT       1
`define W2_RESET         8'h80

// ==========================================================
// timing
`define SYS_CLK_HZ       40000000
`define DB_MIN_MS        6
`define DB_MAX_MS        8
`define MS_CYCLES        (`SYS_CLK_HZ / 1000)
`define DB_TICKS         3'h7
// pulse width in system cycles, sized to fit its 4 bit counter
`define FP_PULSE_CYC     4'h8
`define ALL_ONES         8'hFF

`endif

//--- rtl/word_fifo.v
// Purpose: small flop based fifo with valid/ready on both sides
// Assumes: single clock, asynchronous active high reset
// Notes:   depth is a power of two given by its index width
`timescale 1ns/10ps
`default_nettype none

module word_fifo #(
    parameter W  = 9,
    parameter AW = 2
) (
    input  wire         clk_in,
    input  wire         rst_in,
    input  wire         in_valid_in,
    output wire         in_ready_out,
    input  wire [W-1:0] in_data_in,
    output wire         out_valid_out,
    input  wire         out_ready_in,
    output wire [W-1:0] out_data_out
);

    localparam D = 1 << AW;

    reg [W-1:0]  mem_ff [0:D-1];   // storage words
    reg [AW-1:0] wr_ptr_ff;        // next write index
    reg [AW-1:0] rd_ptr_ff;        // next read index
    reg [AW:0]   count_ff;         // words held
    wire         push;             // accepted write
    wire         pop;              // accepted read

    // honest flags straight from the count
    assign in_ready_out  = (count_ff != D[AW:0]);
    assign out_valid_out = (count_ff != {(AW+1){1'b0}});
    assign out_data_out  = mem_ff[rd_ptr_ff];
    assign push = in_valid_in & in_ready_out;
    assign pop  = out_valid_out & out_ready_in;

    // ==========================================================
    // pointers and count
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            if (push & ~pop)
                count_ff <= count_ff + 1'b1;
            else if (pop & ~push)
                count_ff <= count_ff - 1'b1;
        end
    end

    // storage needs no reset, never read while empty
    always @(posedge clk_in) begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data_in;
    end

endmodule
`default_nettype wire

//--- rtl/mcw_decoder.v
// Purpose: decode the two master control words of the control stream
// Assumes: link bit clock well below half of SYS_CLK_IN
// Notes:   frame start is marked by LINK_FRAME_N_IN low at a bit edge
//
// Summary of operation
// - loopback bit swaps transmitted slot 16 in
// - loopback only with line sync, one slot
// - set debounce bit passes signalling bit raw
// - clear bit debounces signalling 6 to 8 ms
// - ccs sends voice channel 16 in slot 16
// - ccs puts received slot 16 on voice
// - ccs takes slot 16 control from channel 15
// - ccs ignores signalling channels 0 to 15
// - ccs clear carries abcd codes in slot 16
// - enable bit drives 8 kHz framing pulses
// - pulse pin floats when enable clear
// - alarm bit sends all ones everywhere
// - slot 16 alarm sends ones there only
// - external pin follows word two bit 1
`timescale 1ns/10ps
`default_nettype none
`include "mcw_consts.vh"

module mcw_decoder #(
    parameter MS_CYC = `MS_CYCLES,
    parameter FIFO_AW = 2
) (
    input  wire       SYS_CLK_IN,
    input  wire       RST_IN,
    input  wire       LINK_CLK_IN,
    input  wire       LINK_FRAME_N_IN,
    input  wire       CONTROL_SERIAL_IN,
    input  wire       LINE_SYNC_IN,
    input  wire [4:0] TX_SLOT_IN,
    input  wire [7:0] TX_VOICE_IN,
    input  wire [7:0] TX_VOICE_CH16_IN,
    input  wire [7:0] TX_CAS_IN,
    output reg  [7:0] TX_LINE_OUT,
    input  wire [4:0] RX_SLOT_IN,
    input  wire [7:0] RX_LINE_IN,
    output reg  [7:0] RX_VOICE_OUT,
    input  wire [3:0] RX_SIG_IN,
    output reg  [3:0] RX_SIG_OUT,
    input  wire [4:0] SIG_CHAN_IN,
    output reg        SIG_CHAN_USED_OUT,
    output reg        TS16_CTRL_VALID_OUT,
    output reg  [7:0] TS16_CTRL_OUT,
    input  wire       RX_FRAME_IN,
    output reg        FRAME_PULSE_OUT,
    output reg        FRAME_PULSE_OE_N_OUT,
    output reg        EXT_CONTROL_OUT,
    output reg  [7:0] WORD_ONE_OUT,
    output reg  [7:0] WORD_TWO_OUT
);

    // ==========================================================
    // helper functions
    // true for line timeslot 16, used on both directions
    function is_ts16;
        input [4:0] slot;
        begin
            is_ts16 = (slot == `SIG_SLOT);
        end
    endfunction

    // true for the lower sixteen signalling channels
    function low_half;
        input [4:0] chan;
        begin
            low_half = ~chan[4];
        end
    endfunction

    // ==========================================================
    // link pin synchronisers
    reg [1:0] clk_sync_ff;     // bit clock, two stages
    reg [1:0] frm_sync_ff;     // frame marker, two stages
    reg [1:0] dat_sync_ff;     // control data, two stages
    reg       clk_prev_ff;     // last synced bit clock
    wire      bit_edge;        // rising bit clock seen

    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            // idle high level, so no false bit edge after reset
            clk_sync_ff <= 2'h3;
            frm_sync_ff <= 2'h3;
            dat_sync_ff <= 2'h3;
            clk_prev_ff <= 1'b1;
        end else begin
            clk_sync_ff <= {clk_sync_ff[0], LINK_CLK_IN};
            frm_sync_ff <= {frm_sync_ff[0], LINK_FRAME_N_IN};
            dat_sync_ff <= {dat_sync_ff[0], CONTROL_SERIAL_IN};
            clk_prev_ff <= clk_sync_ff[1];
        end
    end

    // only the second stages are looked at
    assign bit_edge = clk_sync_ff[1] & ~clk_prev_ff;

    // ==========================================================
    // control stream deserialiser
    reg [7:0] shift_ff;        // bits of current channel
    reg [4:0] chan_ff;         // channel being received
    reg [2:0] bit_ff;          // bit index within channel
    reg       stage_vld_ff;    // captured word waiting
    reg [8:0] stage_ff;        // {word two flag, word}
    reg       frame_go_ff;     // one cycle at frame start
    wire      frame_start;     // marker low on this edge
    wire [4:0] cur_chan;       // channel of this bit
    wire [2:0] cur_bit;        // bit index of this bit
    wire [7:0] cur_word;       // word including this bit
    wire      fifo_in_rdy;     // fifo accepts
    wire      fifo_out_vld;    // fifo holds a word
    wire [8:0] fifo_out;       // oldest word
    wire      drain_rdy;       // drain side ready

    assign frame_start = bit_edge & ~frm_sync_ff[1];
    assign cur_chan = frame_start ? 5'h00 : chan_ff;
    assign cur_bit  = frame_start ? 3'h0 : bit_ff;
    assign cur_word = {shift_ff[6:0], dat_sync_ff[1]};

    // counts bits msb first, captures word at channel end
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            shift_ff     <= 8'h00;
            chan_ff      <= 5'h00;
            bit_ff       <= 3'h0;
            stage_vld_ff <= 1'b0;
            stage_ff     <= 9'h000;
            frame_go_ff  <= 1'b0;
        end else begin
            frame_go_ff <= frame_start;
            if (stage_vld_ff & fifo_in_rdy)
                stage_vld_ff <= 1'b0;
            if (bit_edge) begin
                shift_ff <= cur_word;
                bit_ff   <= cur_bit + 3'h1;
                if (cur_bit == `LAST_BIT)
                    chan_ff <= cur_chan + 5'h01;
                else
                    chan_ff <= cur_chan;
                // only the two master channels are kept
                if ((cur_bit == `LAST_BIT) &&
                    ((cur_chan == `WORD_ONE_CHAN) ||
                     (cur_chan == `WORD_TWO_CHAN))) begin
                    // a full fifo drops the older staged word
                    stage_vld_ff <= 1'b1;
                    stage_ff <= {cur_chan[4], cur_word};
                end
            end
        end
    end

    // ==========================================================
    // word fifo between capture and decode
    // drain stalls during the apply cycle so pending stays stable
    assign drain_rdy = ~frame_go_ff;

    word_fifo #(
        .W  (9),
        .AW (FIFO_AW)
    ) word_fifo_i (
        .clk_in        (SYS_CLK_IN),
        .rst_in        (RST_IN),
        .in_valid_in   (stage_vld_ff),
        .in_ready_out  (fifo_in_rdy),
        .in_data_in    (stage_ff),
        .out_valid_out (fifo_out_vld),
        .out_ready_in  (drain_rdy),
        .out_data_out  (fifo_out)
    );

    // ==========================================================
    // pending and active words
    reg [7:0] pend1_ff;        // latest word one
    reg [7:0] pend2_ff;        // latest word two
    reg [7:0] w1_ff;           // word one in force
    reg [7:0] w2_ff;           // word two in force

    // words wait in pending until the next frame begins
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pend1_ff <= `W1_RESET;
            pend2_ff <= `W2_RESET;
            w1_ff    <= `W1_RESET;
            w2_ff    <= `W2_RESET;
        end else begin
            if (fifo_out_vld & drain_rdy) begin
                if (fifo_out[8])
                    pend2_ff <= fifo_out[7:0];
                else
                    pend1_ff <= fifo_out[7:0];
            end
            // reserved bits are stored but steer nothing
            if (frame_go_ff) begin
                w1_ff <= pend1_ff;
                w2_ff <= pend2_ff;
            end
        end
    end

    wire ccs_mode  = w2_ff[`W2_CCS_BIT];
    wire all_ones  = w2_ff[`W2_AIS_BIT];
    wire ts16_ones = w2_ff[`W2_TS16AIS_BIT];
    wire loop_on   = w1_ff[`W1_LOOP_BIT] & LINE_SYNC_IN;
    wire [3:0] nodb = w1_ff[`W1_NODB_MSB:0];

    // ==========================================================
    // transmit slot selection
    reg [7:0] tx_ts16_ff;      // last slot 16 sent
    reg [7:0] tx_next;         // next line byte

    always @* begin
        if (all_ones)
            tx_next = `ALL_ONES;
        else if (is_ts16(TX_SLOT_IN) & ts16_ones)
            tx_next = `ALL_ONES;
        else if (is_ts16(TX_SLOT_IN) & ccs_mode)
            tx_next = TX_VOICE_CH16_IN;
        else if (is_ts16(TX_SLOT_IN))
            tx_next = TX_CAS_IN;
        else
            tx_next = TX_VOICE_IN;
    end

    // registered line byte, slot 16 kept for loopback
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            TX_LINE_OUT <= `ALL_ONES;
            tx_ts16_ff  <= `ALL_ONES;
        end else begin
            TX_LINE_OUT <= tx_next;
            if (is_ts16(TX_SLOT_IN))
                tx_ts16_ff <= tx_next;
        end
    end

    // ==========================================================
    // receive path and signalling channel gating
    // only slot 16 is ever replaced, the rest pass
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RX_VOICE_OUT        <= `ALL_ONES;
            SIG_CHAN_USED_OUT   <= 1'b1;
            TS16_CTRL_VALID_OUT <= 1'b0;
            TS16_CTRL_OUT       <= `W1_RESET;
        end else begin
            if (is_ts16(RX_SLOT_IN) & loop_on)
                RX_VOICE_OUT <= tx_ts16_ff;
            else
                RX_VOICE_OUT <= RX_LINE_IN;
            SIG_CHAN_USED_OUT <=
                ~(ccs_mode & low_half(SIG_CHAN_IN));
            TS16_CTRL_VALID_OUT <= ccs_mode;
            TS16_CTRL_OUT       <= w1_ff;
        end
    end

    // ==========================================================
    // signalling bit debounce
    reg [15:0] ms_cnt_ff;      // millisecond divider
    reg        ms_tick_ff;     // one cycle per ms
    reg [2:0]  db_cnt_ff [0:3];// ms ticks of change held
    integer    i;

    // tick granularity gives a 6 to 7 ms wait
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ms_cnt_ff  <= 16'h0000;
            ms_tick_ff <= 1'b0;
        end else if (ms_cnt_ff == MS_CYC[15:0] - 16'h0001) begin
            ms_cnt_ff  <= 16'h0000;
            ms_tick_ff <= 1'b1;
        end else begin
            ms_cnt_ff  <= ms_cnt_ff + 16'h0001;
            ms_tick_ff <= 1'b0;
        end
    end

    // bit 0 is A up to bit 3 as D
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RX_SIG_OUT <= 4'hF;
            for (i = 0; i < 4; i = i + 1)
                db_cnt_ff[i] <= 3'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (nodb[i]) begin
                    RX_SIG_OUT[i] <= RX_SIG_IN[i];
                    db_cnt_ff[i]  <= 3'h0;
                end else if (RX_SIG_IN[i] == RX_SIG_OUT[i]) begin
                    db_cnt_ff[i] <= 3'h0;                  // glitch ends
                end else if (ms_tick_ff) begin
                    if (db_cnt_ff[i] == `DB_TICKS - 3'h1) begin
                        RX_SIG_OUT[i] <= RX_SIG_IN[i];
                        db_cnt_ff[i]  <= 3'h0;
                    end else begin
                        db_cnt_ff[i] <= db_cnt_ff[i] + 3'h1;
                    end
                end
            end
        end
    end

    // ==========================================================
    // recovered frame pulse and external pin
    localparam [3:0] PULSE_CYC = `FP_PULSE_CYC;
    reg [3:0] pulse_cnt_ff;    // remaining high cycles

    // one pulse per received frame while line sync is held gives the 8 kHz train
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pulse_cnt_ff         <= 4'h0;
            FRAME_PULSE_OUT      <= 1'b0;
            FRAME_PULSE_OE_N_OUT <= 1'b1;
            EXT_CONTROL_OUT      <= 1'b0;
            WORD_ONE_OUT         <= `W1_RESET;
            WORD_TWO_OUT         <= `W2_RESET;
        end else begin
            if (RX_FRAME_IN & LINE_SYNC_IN)
                pulse_cnt_ff <= PULSE_CYC;
            else if (pulse_cnt_ff != 4'h0)
                pulse_cnt_ff <= pulse_cnt_ff - 4'h1;
            FRAME_PULSE_OUT <= (pulse_cnt_ff != 4'h0);
            FRAME_PULSE_OE_N_OUT <= ~w2_ff[`W2_FPEN_BIT];
            EXT_CONTROL_OUT <= w2_ff[`W2_EXT_BIT];
            WORD_ONE_OUT    <= w1_ff;
            WORD_TWO_OUT    <= w2_ff;
        end
    end

endmodule
`default_nettype wire

//--- testbench/mcw_decoder_properties.sv
// Purpose: port level checks of the control word decoder
// Assumes: single clock domain, words applied near a frame start
// Notes:   gated one cycle after reset so $past sees real traffic
`timescale 1ns/10ps
`default_nettype none

module mcw_decoder_properties (
    input wire logic       SYS_CLK_IN,
    input wire logic       RST_IN,
    input wire logic       LINK_FRAME_N_IN,
    input wire logic       LINE_SYNC_IN,
    input wire logic [4:0] TX_SLOT_IN,
    input wire logic [7:0] TX_VOICE_IN,
    input wire logic [7:0] TX_LINE_OUT,
    input wire logic [4:0] RX_SLOT_IN,
    input wire logic [7:0] RX_LINE_IN,
    input wire logic [7:0] RX_VOICE_OUT,
    input wire logic [3:0] RX_SIG_IN,
    input wire logic [3:0] RX_SIG_OUT,
    input wire logic [4:0] SIG_CHAN_IN,
    input wire logic       SIG_CHAN_USED_OUT,
    input wire logic       TS16_CTRL_VALID_OUT,
    input wire logic       RX_FRAME_IN,
    input wire logic       FRAME_PULSE_OUT,
    input wire logic       FRAME_PULSE_OE_N_OUT,
    input wire logic       EXT_CONTROL_OUT,
    input wire logic [7:0] WORD_ONE_OUT,
    input wire logic [7:0] WORD_TWO_OUT
);
    logic       up_ff;    // one cycle out of reset
    logic [4:0] since_ff; // cycles since frame marker seen low

    // ==========================================================
    // helper logic
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            up_ff    <= 1'b0;
            since_ff <= 5'h1F;
        end else begin
            up_ff <= 1'b1;
            // saturate so a long quiet spell never wraps
            if (!LINK_FRAME_N_IN) since_ff <= 5'h00;
            else if (since_ff != 5'h1F) since_ff <= since_ff + 5'h01;
        end
    end

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence pulse_high;
        FRAME_PULSE_OUT [*8];
    endsequence
    sequence sync_lost;
        !LINE_SYNC_IN [*2];
    endsequence

    // ==========================================================
    // assertions
    a_ext_follows: assert property (EXT_CONTROL_OUT == WORD_TWO_OUT[1])
        else $error("ext pin differs from word two");
    a_float_off: assert property (FRAME_PULSE_OE_N_OUT == !WORD_TWO_OUT[4])
        else $error("pulse pin enable wrong");
    a_ccs_valid: assert property (TS16_CTRL_VALID_OUT == WORD_TWO_OUT[5])
        else $error("slot 16 control valid wrong");
    a_all_ones: assert property (up_ff && WORD_TWO_OUT[3] &&
        $past(WORD_TWO_OUT[3]) |-> TX_LINE_OUT == 8'hFF)
        else $error("alarm not all ones");
    a_slot16_ones: assert property (up_ff && WORD_TWO_OUT[2] &&
        $past(WORD_TWO_OUT[2]) && $past(TX_SLOT_IN) == 5'h10
        |-> TX_LINE_OUT == 8'hFF) else $error("slot 16 alarm missing");
    a_voice_normal: assert property (up_ff && !WORD_TWO_OUT[3] &&
        !$past(WORD_TWO_OUT[3]) && $past(TX_SLOT_IN) != 5'h10
        |-> TX_LINE_OUT == $past(TX_VOICE_IN)) else $error("voice altered");
    a_rx_single_slot: assert property (up_ff &&
        $past(RX_SLOT_IN) != 5'h10 |-> RX_VOICE_OUT == $past(RX_LINE_IN))
        else $error("received slot altered");
    a_sig_ignored: assert property (up_ff && WORD_TWO_OUT[5] &&
        $past(WORD_TWO_OUT[5]) && $past(SIG_CHAN_IN) < 5'h10
        |-> !SIG_CHAN_USED_OUT) else $error("low channel used in ccs");
    a_bypass_raw: assert property (up_ff && WORD_ONE_OUT[3:0] == 4'hF &&
        $past(WORD_ONE_OUT[3:0]) == 4'hF |-> RX_SIG_OUT == $past(RX_SIG_IN))
        else $error("bypassed bits not raw");
    a_pulse_width: assert property ($rose(FRAME_PULSE_OUT)
        |-> pulse_high ##1 !FRAME_PULSE_OUT) else $error("pulse width wrong");
    a_pulse_cause: assert property ($rose(FRAME_PULSE_OUT)
        |-> $past(RX_FRAME_IN) || $past(RX_FRAME_IN, 2))
        else $error("pulse without frame");
    a_pulse_sync: assert property (sync_lost |-> !$rose(FRAME_PULSE_OUT))
        else $error("pulse without line sync");
    a_apply_at_frame: assert property (up_ff &&
        (!$stable(WORD_ONE_OUT) || !$stable(WORD_TWO_OUT))
        |-> since_ff < 5'h10) else $error("words changed mid frame");
endmodule

bind mcw_decoder mcw_decoder_properties mcw_decoder_properties_i (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
    .LINK_FRAME_N_IN(LINK_FRAME_N_IN), .LINE_SYNC_IN(LINE_SYNC_IN),
    .TX_SLOT_IN(TX_SLOT_IN), .TX_VOICE_IN(TX_VOICE_IN),
    .TX_LINE_OUT(TX_LINE_OUT), .RX_SLOT_IN(RX_SLOT_IN),
    .RX_LINE_IN(RX_LINE_IN), .RX_VOICE_OUT(RX_VOICE_OUT),
    .RX_SIG_IN(RX_SIG_IN), .RX_SIG_OUT(RX_SIG_OUT),
    .SIG_CHAN_IN(SIG_CHAN_IN), .SIG_CHAN_USED_OUT(SIG_CHAN_USED_OUT),
    .TS16_CTRL_VALID_OUT(TS16_CTRL_VALID_OUT), .RX_FRAME_IN(RX_FRAME_IN),
    .FRAME_PULSE_OUT(FRAME_PULSE_OUT),
    .FRAME_PULSE_OE_N_OUT(FRAME_PULSE_OE_N_OUT),
    .EXT_CONTROL_OUT(EXT_CONTROL_OUT),
    .WORD_ONE_OUT(WORD_ONE_OUT), .WORD_TWO_OUT(WORD_TWO_OUT));
`default_nettype wire

//--- testbench/host_stream_model.sv
// Purpose: host model shifting the serial control stream
// Assumes: 32 channels of 8 bits, msb first, 200 ns bit clock
// Notes:   bit clock stands still high between frames
`timescale 1ns/10ps
`default_nettype none

module host_stream_model (
    output logic link_clk_out,
    output logic frame_n_out,
    output logic data_out
);
    integer     b; // bit index in frame
    logic [7:0] w; // channel byte in flight

    initial begin
        link_clk_out = 1'b1;
        frame_n_out  = 1'b1;
        data_out     = 1'b0;
    end

    // ==========================================================
    // one frame; other channels carry a changing filler
    task send_frame(input logic [7:0] w1, input logic [7:0] w2);
        begin
            #7;
            for (b = 0; b < 256; b = b + 1) begin
                w = (b[7:3] == 5'h0F) ? w1 :
                    (b[7:3] == 5'h1F) ? w2 : 8'h5A ^ b[7:0];
                #100 link_clk_out = 1'b0;
                frame_n_out = (b != 0);
                data_out    = w[3'h7 - b[2:0]];
                #100 link_clk_out = 1'b1;
            end
            #100 frame_n_out = 1'b1;
            // no stale bit left on the line after release
            data_out = ~data_out;
        end
    endtask
endmodule
`default_nettype wire

//--- testbench/mcw_decoder_test.sv
// Purpose: self checking bench for the control word decoder
// Assumes: debounce millisecond shortened to 40 cycles
// Notes:   inputs change at the falling clock edge
`timescale 1ns/10ps
`default_nettype none

module mcw_decoder_test;
    logic       sys_clk, rst, link_clk, frame_n, ctl, sync, rx_frame;
    logic [4:0] tx_slot, rx_slot, sig_chan;
    logic [7:0] tx_voice, tx_ch16, tx_cas, rx_line;
    logic [3:0] rx_sig;
    wire  [7:0] tx_line, rx_voice, ts16_ctrl, word_one, word_two;
    wire  [3:0] sig_out;
    wire        used, ts16_vld, pulse_o, oe_n, ext;
    integer     errors, checks, cycles;

    host_stream_model host_stream_model_i (.link_clk_out(link_clk),
        .frame_n_out(frame_n), .data_out(ctl));

    mcw_decoder #(.MS_CYC(40), .FIFO_AW(2)) mcw_decoder_i (
        .SYS_CLK_IN(sys_clk), .RST_IN(rst), .LINK_CLK_IN(link_clk),
        .LINK_FRAME_N_IN(frame_n), .CONTROL_SERIAL_IN(ctl),
        .LINE_SYNC_IN(sync), .TX_SLOT_IN(tx_slot), .TX_VOICE_IN(tx_voice),
        .TX_VOICE_CH16_IN(tx_ch16), .TX_CAS_IN(tx_cas),
        .TX_LINE_OUT(tx_line), .RX_SLOT_IN(rx_slot), .RX_LINE_IN(rx_line),
        .RX_VOICE_OUT(rx_voice), .RX_SIG_IN(rx_sig), .RX_SIG_OUT(sig_out),
        .SIG_CHAN_IN(sig_chan), .SIG_CHAN_USED_OUT(used),
        .TS16_CTRL_VALID_OUT(ts16_vld), .TS16_CTRL_OUT(ts16_ctrl),
        .RX_FRAME_IN(rx_frame), .FRAME_PULSE_OUT(pulse_o),
        .FRAME_PULSE_OE_N_OUT(oe_n), .EXT_CONTROL_OUT(ext),
        .WORD_ONE_OUT(word_one), .WORD_TWO_OUT(word_two));

    // ==========================================================
    // clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            test_done;
        end
    end

    // ==========================================================
    // shared tasks
    task test_done;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask
    task check(input string name, input logic [7:0] seen, exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask
    // two frames: words staged by the first, in force from the second
    task words(input logic [7:0] w1, w2, old2);
        begin
            host_stream_model_i.send_frame(w1, w2);
            cyc(4);
            check("word held", word_two, old2);
            host_stream_model_i.send_frame(w1, w2);
            cyc(4);
            check("word one", word_one, w1);
            check("word two", word_two, w2);
            check("ext pin", {7'h00, ext}, {7'h00, w2[1]});
            check("float", {7'h00, oe_n}, {7'h00, ~w2[4]});
            check("ccs", {7'h00, ts16_vld}, {7'h00, w2[5]});
            if (w2[5]) check("ts16 ctrl", ts16_ctrl, w1);
        end
    endtask
    task tx(input logic [4:0] slot, input logic [7:0] exp);
        begin
            tx_slot = slot;
            cyc(1);
            check("tx line", tx_line, exp);
        end
    endtask
    task rx(input logic [4:0] slot, input logic s, input logic [7:0] exp);
        begin
            rx_slot = slot;
            sync    = s;
            cyc(1);
            check("rx voice", rx_voice, exp);
        end
    endtask
    task chan(input logic [4:0] ch, input logic exp);
        begin
            sig_chan = ch;
            cyc(1);
            check("chan used", {7'h00, used}, {7'h00, exp});
        end
    endtask
    task pulse(input logic s, input logic [7:0] len);
        integer n;
        begin
            n        = 0;
            sync     = s;
            rx_frame = 1'b1;
            cyc(1);
            rx_frame = 1'b0;
            repeat (20) begin
                cyc(1);
                if (pulse_o === 1'b1) n = n + 1;
            end
            check("pulse len", n[7:0], len);
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        errors = 0;   checks = 0;   cycles = 0;
        rst = 1'b1;   sync = 1'b1;  rx_frame = 1'b0;
        tx_slot = 5'h00;  rx_slot = 5'h00;  sig_chan = 5'h00;
        tx_voice = 8'h3C; tx_ch16 = 8'hC3;  tx_cas = 8'h96;
        rx_line = 8'h69;  rx_sig = 4'h5;
        cyc(6);
        rst = 1'b0;
        cyc(3);
        check("float", {7'h00, oe_n}, 8'h01);
        // cas mode, bypass, pulse enabled, ext high; reserved bits kept
        words(8'hBF, 8'h92, 8'h80);
        tx(5'h03, 8'h3C);
        tx(5'h10, 8'h96);
        rx(5'h05, 1'b1, 8'h69);
        rx_sig = 4'hA;
        cyc(1);
        check("sig raw", {4'h0, sig_out}, 8'h0A);
        chan(5'h03, 1'b1);
        pulse(1'b1, 8'h08);
        pulse(1'b0, 8'h00);
        // ccs with slot 16 loopback, all bits debounced
        words(8'hF0, 8'hA0, 8'h92);
        tx(5'h10, 8'hC3);
        tx(5'h03, 8'h3C);
        rx(5'h10, 1'b1, 8'hC3);
        rx(5'h10, 1'b0, 8'h69);
        rx(5'h05, 1'b1, 8'h69);
        chan(5'h03, 1'b0);
        chan(5'h14, 1'b1);
        rx_sig = 4'h5;
        cyc(200);
        check("sig early", {4'h0, sig_out}, 8'h0A);
        cyc(140);
        check("sig late", {4'h0, sig_out}, 8'h05);
        // slot 16 alarm only, then whole frame alarm
        words(8'hBF, 8'h84, 8'hA0);
        tx(5'h03, 8'h3C);
        tx(5'h10, 8'hFF);
        words(8'hBF, 8'h88, 8'h84);
        tx(5'h03, 8'hFF);
        tx(5'h10, 8'hFF);
        // ccs without loopback passes received slot 16
        words(8'hBF, 8'hA0, 8'h88);
        rx(5'h10, 1'b1, 8'h69);
        test_done;
    end
endmodule
`default_nettype wire
